/* hw/pbs_defs.vh */
`ifndef PBS_DEFS_VH
`define PBS_DEFS_VH

`define PBS_ADDR_W      15
`define PBS_DEPTH       32768
`define PBS_DATA_W      36
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_BCNT_W      2
`define PBS_BCNT_ZERO   2'h0
`define PBS_BCNT_ONE    2'h1
`define PBS_WBUF_DEPTH  16
`define PBS_WBUF_AW     4

`endif

/* hw/pbs_fifo.v */
`timescale 1ns/10ps
`default_nettype none

module pbs_fifo #(
    parameter W  = 8,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire          i_clk,       // clock
    input  wire          i_rst,       // async reset, high
    input  wire          i_in_valid,  // push request
    output wire          o_in_ready,  // room for a word
    input  wire [W-1:0]  i_in_data,   // pushed word
    output wire          o_out_valid, // word available
    input  wire          i_out_ready, // pop request
    output wire [W-1:0]  o_out_data   // oldest word
);

    reg [W-1:0]  mem [0:D-1];
    reg [AW:0]   wr_ptr_ff;
    reg [AW:0]   rd_ptr_ff;
    wire         push;
    wire         pop;

    // extra pointer bit tells full from empty
    assign o_out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign o_in_ready  = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) || (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_ptr_ff[AW-1:0]];

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // pbs_fifo

`default_nettype wire

/* hw/pbs_sram.v */
`timescale 1ns/10ps
`default_nettype none
`include "pbs_defs.vh"

module pbs_sram #(
    parameter ADDR_W  = `PBS_ADDR_W,
    parameter DEPTH   = `PBS_DEPTH,
    parameter DATA_W  = `PBS_DATA_W,
    parameter LANES   = `PBS_LANES,
    parameter LANE_W  = `PBS_LANE_W,
    parameter WBUF_D  = `PBS_WBUF_DEPTH,
    parameter WBUF_AW = `PBS_WBUF_AW
) (
    input  wire              i_clk,                // clock
    input  wire              i_rst,                // async reset, high
    input  wire [ADDR_W-1:0] i_sync_addr_in,       // word address, [1:0] are burst lsbs
    input  wire              i_cpu_addr_strobe_n,  // cpu address strobe, low
    input  wire              i_ctrl_addr_strobe_n, // controller address strobe, low
    input  wire              i_burst_advance_n,    // burst advance, low
    input  wire              i_chip_enable_low_a_n,// first chip enable, low
    input  wire              i_chip_enable_high,   // second chip enable, high
    input  wire              i_chip_enable_low_b_n,// third chip enable, low
    input  wire [LANES-1:0]  i_lane_write_strobe_n,// lane write strobes, low
    input  wire              i_lane_write_enable_n,// lane write enable, low
    input  wire              i_all_lanes_write_n,  // global write, low
    input  wire              i_burst_order_sel,    // 0 linear, 1 interleaved
    input  wire              i_out_enable_n,       // async output enable, low
    input  wire [DATA_W-1:0] i_lane_data_io,       // data pins, input side
    output wire [DATA_W-1:0] o_lane_data_io,       // data pins, output side
    output wire              o_lane_data_oe,       // data pins driven
    output wire              o_wbuf_ready,         // write buffer can take a write
    output wire              o_wbuf_empty          // all writes reached the array
);

    localparam CW = `PBS_BCNT_W;
    localparam WB_W = ADDR_W + DATA_W + LANES;

    // input registers
    reg [ADDR_W-1:0] in_addr_ff;
    reg [DATA_W-1:0] in_data_ff;
    reg              in_cpu_n_ff;
    reg              in_ctrl_n_ff;
    reg              in_adv_n_ff;
    reg              in_ce_a_n_ff;
    reg              in_ce_h_ff;
    reg              in_ce_b_n_ff;
    reg [LANES-1:0]  in_sb_n_ff;
    reg              in_we_n_ff;
    reg              in_gw_n_ff;
    // order select is a pin from outside, synchronised
    reg              order_s1_ff;
    reg              order_s2_ff;

    // burst state
    reg              act_ff;
    reg [ADDR_W-1:0] base_ff;
    reg [CW-1:0]     cnt_ff;
    reg              nxt_act;
    reg [ADDR_W-1:0] nxt_base;
    reg [CW-1:0]     nxt_cnt;
    reg              do_access;
    reg [CW-1:0]     lo_bits;
    wire [ADDR_W-1:0] cyc_addr;

    // read pipeline
    reg              rd1_ff;
    reg              drv_ff;
    reg [DATA_W-1:0] dq_ff;
    wire [DATA_W-1:0] rd_q;

    // write path
    wire             wr_req;
    reg [LANES-1:0]  wr_lanes;
    wire             do_rd;
    wire             do_wr;
    wire             wb_out_valid;
    wire [WB_W-1:0]  wb_out_data;
    wire             drain;
    wire [ADDR_W-1:0] wb_addr;
    wire [DATA_W-1:0] wb_data;
    wire [LANES-1:0]  wb_lanes;
    wire              any_lane;

    // decode terms
    wire              cpu_go;
    wire              ctrl_go;
    wire              ce_all;

    // forwarding from the write buffer head
    wire              same_addr;
    wire [LANES-1:0]  fwd_hit;
    wire [DATA_W-1:0] fwd_q;

    // address capture
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_addr_ff <= {ADDR_W{1'b0}};
        end else begin
            in_addr_ff <= i_sync_addr_in;
        end
    end

    // data pins sampled every edge; only a write uses them
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_data_ff <= {DATA_W{1'b0}};
        end else begin
            in_data_ff <= i_lane_data_io;
        end
    end

    // strobes and advance
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_cpu_n_ff  <= 1'b1;
            in_ctrl_n_ff <= 1'b1;
            in_adv_n_ff  <= 1'b1;
        end else begin
            in_cpu_n_ff  <= i_cpu_addr_strobe_n;
            in_ctrl_n_ff <= i_ctrl_addr_strobe_n;
            in_adv_n_ff  <= i_burst_advance_n;
        end
    end

    // all three enables sampled, so several parts can share one bus
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_ce_a_n_ff <= 1'b1;
            in_ce_h_ff   <= 1'b0;
            in_ce_b_n_ff <= 1'b1;
        end else begin
            in_ce_a_n_ff <= i_chip_enable_low_a_n;
            in_ce_h_ff   <= i_chip_enable_high;
            in_ce_b_n_ff <= i_chip_enable_low_b_n;
        end
    end

    // write controls
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_sb_n_ff <= {LANES{1'b1}};
            in_we_n_ff <= 1'b1;
            in_gw_n_ff <= 1'b1;
        end else begin
            in_sb_n_ff <= i_lane_write_strobe_n;
            in_we_n_ff <= i_lane_write_enable_n;
            in_gw_n_ff <= i_all_lanes_write_n;
        end
    end

    // a strap change mid-burst would split the sequence; it must stay static
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            order_s1_ff <= 1'b0;
            order_s2_ff <= 1'b0;
        end else begin
            order_s1_ff <= i_burst_order_sel;
            order_s2_ff <= order_s1_ff;
        end
    end

    // write request and lane selection from the sampled controls
    assign any_lane = (in_sb_n_ff != {LANES{1'b1}});
    assign wr_req   = !in_gw_n_ff || (!in_we_n_ff && any_lane);

    always @* begin
        if (!in_gw_n_ff) begin
            wr_lanes = {LANES{1'b1}};
        end else if (!in_we_n_ff) begin
            wr_lanes = ~in_sb_n_ff;
        end else begin
            wr_lanes = {LANES{1'b0}};
        end
    end

    // cpu strobe counts only while the first enable is low
    assign cpu_go  = !in_cpu_n_ff && !in_ce_a_n_ff;
    assign ctrl_go = !in_ctrl_n_ff;
    assign ce_all  = !in_ce_a_n_ff && in_ce_h_ff && !in_ce_b_n_ff;

    // cycle decode; cpu strobe only reads, and only with the first enable low
    always @* begin
        nxt_act   = act_ff;
        nxt_base  = base_ff;
        nxt_cnt   = cnt_ff;
        do_access = 1'b0;
        if (cpu_go) begin
            nxt_base  = in_addr_ff;
            nxt_cnt   = `PBS_BCNT_ZERO;
            nxt_act   = ce_all;
            do_access = ce_all;
        end else if (ctrl_go) begin
            nxt_base  = in_addr_ff;
            nxt_cnt   = `PBS_BCNT_ZERO;
            nxt_act   = ce_all;
            do_access = ce_all;
        end else if (act_ff) begin
            if (!in_adv_n_ff) begin
                nxt_cnt = cnt_ff + `PBS_BCNT_ONE;
            end
            do_access = 1'b1;
        end
    end

    always @* begin
        case (order_s2_ff)
            1'b1: begin
                lo_bits = nxt_base[CW-1:0] ^ nxt_cnt;
            end
            default: begin
                lo_bits = nxt_base[CW-1:0] + nxt_cnt;
            end
        endcase
    end

    assign cyc_addr = {nxt_base[ADDR_W-1:CW], lo_bits};

    // cpu strobe cycle is always a read; write begins on the following cycle
    assign do_wr = do_access && wr_req && !cpu_go;
    assign do_rd = do_access && !do_wr;

    // deselect clears the active flag; base and count are don't-care then
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            act_ff <= 1'b0;
        end else begin
            act_ff <= nxt_act;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            base_ff <= {ADDR_W{1'b0}};
        end else begin
            base_ff <= nxt_base;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= `PBS_BCNT_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // writes are posted; the head drains every cycle, so at most one waits
    pbs_fifo #(
        .W  (WB_W),
        .D  (WBUF_D),
        .AW (WBUF_AW)
    ) u_wbuf (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (do_wr),
        .o_in_ready  (o_wbuf_ready),
        .i_in_data   ({cyc_addr, in_data_ff, wr_lanes}),
        .o_out_valid (wb_out_valid),
        .i_out_ready (drain),
        .o_out_data  (wb_out_data)
    );

    assign drain        = wb_out_valid;
    assign same_addr    = wb_out_valid && (wb_addr == cyc_addr);
    assign o_wbuf_empty = !wb_out_valid;
    assign wb_lanes     = wb_out_data[LANES-1:0];
    assign wb_data      = wb_out_data[LANES+DATA_W-1:LANES];
    assign wb_addr      = wb_out_data[WB_W-1:LANES+DATA_W];

    genvar ln;
    generate
        for (ln = 0; ln < LANES; ln = ln + 1) begin : g_lane
            reg [LANE_W-1:0] lane_mem [0:DEPTH-1];
            reg [LANE_W-1:0] q_ff;
            always @(posedge i_clk) begin
                if (drain && wb_lanes[ln]) begin
                    lane_mem[wb_addr] <= wb_data[ln*LANE_W +: LANE_W];
                end
                if (do_rd) begin
                    q_ff <= fwd_q[ln*LANE_W +: LANE_W];
                end
            end
            // a read right after a write sees the queued lane, not the stale word
            assign fwd_hit[ln] = same_addr && wb_lanes[ln];
            assign fwd_q[ln*LANE_W +: LANE_W] = fwd_hit[ln] ? wb_data[ln*LANE_W +: LANE_W] : lane_mem[cyc_addr];
            assign rd_q[ln*LANE_W +: LANE_W] = q_ff;
        end
    endgenerate

    // drive flag trails the array read by one edge, in step with the data
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd1_ff <= 1'b0;
        end else begin
            rd1_ff <= do_rd;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            drv_ff <= 1'b0;
        end else begin
            drv_ff <= rd1_ff;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dq_ff <= {DATA_W{1'b0}};
        end else if (rd1_ff) begin
            dq_ff <= rd_q;
        end
    end

    assign o_lane_data_io = dq_ff;
    // no clock in this term; the host keeps it high around writes
    assign o_lane_data_oe = drv_ff && !i_out_enable_n;

endmodule // pbs_sram

`default_nettype wire

/* verif/pbs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pbs_host_model (
    input  wire logic        i_clk,     // clock
    input  wire logic [35:0] i_dev_q,   // device data
    input  wire logic        i_dev_oe,  // device drives
    input  wire logic [35:0] i_host_d,  // host data
    input  wire logic        i_host_oe, // host drives
    output logic      [35:0] o_wire     // pin level
);
    logic [35:0] last_ff = 36'h0;
    always @(posedge i_clk)
        last_ff <= o_wire;
    // released pins show a changing pattern so stale data never looks valid
    assign o_wire = i_host_oe ? i_host_d : i_dev_oe ? i_dev_q : ~last_ff;
endmodule // pbs_host_model
`default_nettype wire

/* verif/pbs_sram_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module pbs_sram_monitor (
    input wire logic       i_clk,                 // clock
    input wire logic       i_rst,                 // reset
    input wire logic       i_cpu_addr_strobe_n,   // cpu strobe
    input wire logic       i_ctrl_addr_strobe_n,  // ctrl strobe
    input wire logic       i_chip_enable_low_a_n, // enable 1
    input wire logic       i_chip_enable_high,    // enable 2
    input wire logic       i_chip_enable_low_b_n, // enable 3
    input wire logic [3:0] i_lane_write_strobe_n, // strobes
    input wire logic       i_lane_write_enable_n, // write enable
    input wire logic       i_all_lanes_write_n,   // global write
    input wire logic       i_out_enable_n,        // output enable
    input wire logic       o_lane_data_oe,        // pins driven
    input wire logic       o_wbuf_empty           // drained
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    wire ce_on = !i_chip_enable_low_a_n && i_chip_enable_high && !i_chip_enable_low_b_n;
    wire wr_req = !i_all_lanes_write_n || (!i_lane_write_enable_n && i_lane_write_strobe_n != 4'hF);
    wire ctrl_go = !i_ctrl_addr_strobe_n && i_cpu_addr_strobe_n && ce_on;
    wire go_any = !i_ctrl_addr_strobe_n || (!i_cpu_addr_strobe_n && !i_chip_enable_low_a_n);
    AST_READ_LAT: assert property (ctrl_go && !wr_req ##3 !i_out_enable_n |-> o_lane_data_oe)
        else $error("read not driven");
    AST_CPU_READ: assert property (!i_cpu_addr_strobe_n && ce_on ##3 !i_out_enable_n |-> o_lane_data_oe)
        else $error("cpu read not driven");
    AST_CE1_DESEL: assert property (!i_ctrl_addr_strobe_n && i_chip_enable_low_a_n |-> ##3 !o_lane_data_oe)
        else $error("enable 1 no deselect");
    AST_CE2_DESEL: assert property (go_any && !i_chip_enable_high |-> ##3 !o_lane_data_oe)
        else $error("enable 2 no deselect");
    AST_CE3_DESEL: assert property (go_any && i_chip_enable_low_b_n |-> ##3 !o_lane_data_oe)
        else $error("enable 3 no deselect");
    AST_OE_ASYNC: assert property (o_lane_data_oe |-> !i_out_enable_n)
        else $error("driven while disabled");
    AST_WR_POST: assert property (ctrl_go && wr_req |-> ##2 !o_wbuf_empty)
        else $error("write not posted");
    AST_WR_DRAIN: assert property ($fell(o_wbuf_empty) |-> ##[1:40] o_wbuf_empty)
        else $error("write not drained");
endmodule // pbs_sram_monitor
bind pbs_sram pbs_sram_monitor i_mon (
    .i_clk, .i_rst, .i_cpu_addr_strobe_n, .i_ctrl_addr_strobe_n, .i_chip_enable_low_a_n,
    .i_chip_enable_high, .i_chip_enable_low_b_n, .i_lane_write_strobe_n, .i_lane_write_enable_n,
    .i_all_lanes_write_n, .i_out_enable_n, .o_lane_data_oe, .o_wbuf_empty
);
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [12:0] BASE = 13'h0A9;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        cpu_n, ctrl_n, adv_n, we_n, gw_n, ord, oe_n, hoe, q_oe, wempty, wrdy;
    logic [2:0]  ce;
    logic [3:0]  sb_n;
    logic [14:0] addr;
    logic [35:0] hd, pin, q;
    logic [35:0] m [4];
    logic [7:0]  seq;
    int          checks = 0;
    int          failures = 0;
    pbs_host_model i_host (.i_clk(clk), .i_dev_q(q), .i_dev_oe(q_oe), .i_host_d(hd), .i_host_oe(hoe), .o_wire(pin));
    pbs_sram i_dut (
        .i_clk(clk), .i_rst(rst), .i_sync_addr_in(addr), .i_cpu_addr_strobe_n(cpu_n),
        .i_ctrl_addr_strobe_n(ctrl_n), .i_burst_advance_n(adv_n), .i_chip_enable_low_a_n(ce[2]),
        .i_chip_enable_high(ce[1]), .i_chip_enable_low_b_n(ce[0]), .i_lane_write_strobe_n(sb_n),
        .i_lane_write_enable_n(we_n), .i_all_lanes_write_n(gw_n), .i_burst_order_sel(ord),
        .i_out_enable_n(oe_n), .i_lane_data_io(pin), .o_lane_data_io(q), .o_lane_data_oe(q_oe),
        .o_wbuf_ready(wrdy), .o_wbuf_empty(wempty)
    );
    initial forever #10 clk = ~clk;
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        results();
    end
    task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic idle();
        {cpu_n, ctrl_n, adv_n, we_n, gw_n} = 5'h1F;
        sb_n = 4'hF;
        hoe = 1'h0;
        ce = 3'h2;
    endtask
    task automatic desel();
        idle();
        {ctrl_n, ce} = 4'h6;
        @(negedge clk);
        idle();
    endtask
    task automatic drain();
        for (int k = 0; k < 40 && wempty !== 1'h1; k++)
            @(negedge clk);
        chk("empty", wempty, 1'h1);
        chk("ready", wrdy, 1'h1);
    endtask
    // order select passes two sync flops, so let it settle first
    task automatic wr_burst(input logic o, input logic [1:0] s);
        logic [1:0] lo;
        ord = o;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            lo = o ? s ^ 2'(i) : s + 2'(i);
            idle();
            {ctrl_n, adv_n} = i ? 2'h2 : 2'h1;
            gw_n = 1'h0;
            oe_n = 1'h1;
            hoe = 1'h1;
            addr = {BASE, s};
            seq++;
            hd = {seq, 28'h5A5A5A5};
            m[lo] = hd;
            @(negedge clk);
        end
        desel();
        drain();
    endtask
    task automatic rd_burst(input logic o, input logic cpu, input logic [1:0] s);
        logic [1:0] lo;
        ord = o;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 7; i++) begin
            lo = 2'(i - 3);
            if (i > 2) begin
                chk("oe", q_oe, 1'h1);
                chk("rdata", q, m[o ? s ^ lo : s + lo]);
            end
            idle();
            oe_n = 1'h0;
            addr = {BASE, s};
            if (i == 0)
                {cpu_n, ctrl_n} = cpu ? 2'h1 : 2'h2;
            else if (i < 4)
                adv_n = 1'h0;
            else if (i == 4)
                {ctrl_n, ce} = 4'h6;
            @(negedge clk);
        end
    endtask
    task automatic bw(input logic [1:0] lo, input logic [3:0] s);
        idle();
        {ctrl_n, we_n, oe_n} = 3'h1;
        sb_n = s;
        hoe = 1'h1;
        addr = {BASE, lo};
        seq++;
        hd = {seq, 28'hC3C3C3C};
        for (int l = 0; l < 4; l++)
            if (!s[l]) m[lo][l*9+:9] = hd[l*9+:9];
        @(negedge clk);
        desel();
    endtask
    task automatic oe_desel();
        logic [2:0] cet [4] = '{3'h0, 3'h3, 3'h6, 3'h6};
        idle();
        {oe_n, ctrl_n} = 2'h0;
        addr = {BASE, 2'h0};
        @(negedge clk);
        idle();
        repeat (2) @(negedge clk);
        chk("oe", q_oe, 1'h1);
        oe_n = 1'h1;
        #1 chk("oe_off", q_oe, 1'h0);
        oe_n = 1'h0;
        #1 chk("oe_on", q_oe, 1'h1);
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            {cpu_n, ctrl_n} = k[0] ? 2'h1 : 2'h2;
            ce = cet[k];
            @(negedge clk);
            idle();
            repeat (2) @(negedge clk);
            chk("desel", q_oe, 1'h0);
        end
    endtask
    initial begin
        idle();
        oe_n = 1'h1;
        ord = 1'h0;
        addr = 15'h0;
        hd = 36'h0;
        seq = 8'h0;
        repeat (3) @(negedge clk);
        rst = 1'h0;
        chk("rst_oe", q_oe, 1'h0);
        chk("rst_empty", wempty, 1'h1);
        chk("rst_ready", wrdy, 1'h1);
        wr_burst(1'h0, 2'h2);
        rd_burst(1'h1, 1'h0, 2'h3);
        wr_burst(1'h1, 2'h1);
        rd_burst(1'h0, 1'h1, 2'h1);
        bw(2'h1, 4'hA);
        bw(2'h2, 4'h0);
        bw(2'h3, 4'hF);
        drain();
        rd_burst(1'h0, 1'h0, 2'h0);
        oe_desel();
        results();
    end
endmodule // tb_top
`default_nettype wire
